/* File: verilog/lcm_defs.svh */
// Purpose: offsets, field positions and reset values of the logic cell
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   definitions only
`ifndef LCM_DEFS_SVH
`define LCM_DEFS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define LCM_OFS_CONFIG      8'h00
`define LCM_OFS_TABLE       8'h04
`define LCM_OFS_STATUS      8'h08
`define LCM_OFS_FORCE       8'h0C

// ----------------------------------------------------------------
// config field positions
// ----------------------------------------------------------------
`define LCM_CFG_MODE_LSB    0
`define LCM_CFG_MODE_MSB    1
`define LCM_CFG_CARRY_C     2
`define LCM_CFG_CASC_USE    3
`define LCM_CFG_CASC_OR     4
`define LCM_CFG_PACKED      5
`define LCM_CFG_CLK_SEL     6
`define LCM_CFG_RTYPE_LSB   7
`define LCM_CFG_RTYPE_MSB   9
`define LCM_CFG_PRESET      10
`define LCM_CFG_CHIP_RST    11
`define LCM_CFG_FEEDBACK    12
`define LCM_CFG_PRE_LOAD    13
`define LCM_CFG_WIDTH       14

// ----------------------------------------------------------------
// status field positions
// ----------------------------------------------------------------
`define LCM_STS_REG         0
`define LCM_STS_COMB        1
`define LCM_STS_CARRY       2
`define LCM_STS_CASC        3
`define LCM_STS_UNDEF       4
`define LCM_STS_STORED      5

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define LCM_RST_CONFIG      14'h0000
`define LCM_RST_TABLE       16'h0000

`endif

/* File: verilog/lcm_pkg.sv */
// Purpose: types of the logic cell
// Assumes: lcm_defs.svh holds the numbers
// Notes:   all cell state is one packed struct
package lcm_pkg;

    `include "lcm_defs.svh"

    typedef enum logic [1:0]
    {
        LCM_MODE_NORMAL  = 2'h0,
        LCM_MODE_ARITH   = 2'h1,
        LCM_MODE_COUNTER = 2'h3
    } lcm_mode_type;

    typedef enum logic [2:0]
    {
        LCM_REG_D      = 3'h0,
        LCM_REG_T      = 3'h1,
        LCM_REG_JK     = 3'h2,
        LCM_REG_SR     = 3'h3,
        LCM_REG_BYPASS = 3'h4
    } lcm_regtype_type;

    typedef struct packed
    {
        logic                        stored;
        logic                        undefinedFlag;
        logic [`LCM_CFG_WIDTH-1:0]   cfgWord;
        logic [15:0]                 lutMask;
        logic [31:0]                 prdata;
        logic                        pslverr;
    } lcm_state_type;

endpackage

/* File: verilog/lcm_logic_cell.sv */
// Purpose: one configurable logic cell with its register, reached over APB
// Assumes: all inputs synchronous to clock; cluster lines come from outside
// Notes:   zero-wait APB slave; asynchronous controls act on the outputs
//          at once and on the stored bit at the next edge
//
// Local design decisions: the APB register port and the address map.
`timescale 1ns/10ps

`include "lcm_defs.svh"

// How it works
// - config picks exactly one mode: normal, arithmetic or counter
// - seven inputs: four data, own feedback, carry-in, cascade-in
// - register controls all come from shared cluster lines
// - two cluster clock enables; the cell selects one
// - normal mode: 4-input table; carry-in may replace input c
// - normal mode: table merged with cascade-in drives cascade-out
// - packed register in normal mode, not when carry-in is used
// - every cell except the second has a feedback selector
// - arithmetic: two 3-input tables on a, b, carry-in: result and carry
// - arithmetic mode may use cascade together with carry
// - arithmetic gives registered and unregistered result together
// - counter: enables, direction, sync clear/load; enable, direction from data
// - inputs a and b supply enable, direction, feedback except in second cell
// - shared sync clear and load act on every cluster register
// - counter: count table, carry table, load selector, clear AND
// - counter: sync clear or load beats the cascade value
// - sync clear beats sync load on the same edge
// - async clear is direct; preset by inverted storage
// - preset-plus-load emulation is undefined after reset
// - enabled chip reset resets the register above all controls
// - inverted-storage register ends preset after chip reset
// - chip reset use is a static configuration bit
// - each clock pairs with its own enable
// - register acts as D, T, JK, SR or is bypassed
module lcm_logic_cell
#(
    parameter int CELL_POSITION = 0
)
(
    input  wire logic         clock,
    input  wire logic         rstn,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [7:0]   paddr,
    input  wire logic [31:0]  pwdata,
    output logic              pready,
    output logic [31:0]       prdata,
    output logic              pslverr,
    input  wire logic         cellInputA,
    input  wire logic         cellInputB,
    input  wire logic         cellInputC,
    input  wire logic         cellInputD,
    input  wire logic         carryIn,
    input  wire logic         cascadeIn,
    input  wire logic         clusterClockEnableOne,
    input  wire logic         clusterClockEnableTwo,
    input  wire logic         asyncClear,
    input  wire logic         asyncLoad,
    input  wire logic         syncClear,
    input  wire logic         syncLoad,
    input  wire logic         chipResetN,
    output logic              combOut,
    output logic              regOut,
    output logic              carryOut,
    output logic              cascadeOut
);
    import lcm_pkg::*;

    lcm_state_type state;
    lcm_state_type next_state;

    // ----------------------------------------------------------------
    // configuration fields
    // ----------------------------------------------------------------
    lcm_mode_type    mode;
    lcm_regtype_type regType;
    logic            carryForC;
    logic            cascadeUse;
    logic            cascadeOr;
    logic            packed_;
    logic            clockSel;
    logic            presetMode;
    logic            chipResetUse;
    logic            feedbackSel;
    logic            presetLoadEmu;

    always_comb
    begin
        mode          = lcm_mode_type'(state.cfgWord[`LCM_CFG_MODE_MSB:`LCM_CFG_MODE_LSB]);
        regType       = lcm_regtype_type'(state.cfgWord[`LCM_CFG_RTYPE_MSB:`LCM_CFG_RTYPE_LSB]);
        carryForC     = state.cfgWord[`LCM_CFG_CARRY_C];
        cascadeUse    = state.cfgWord[`LCM_CFG_CASC_USE];
        cascadeOr     = state.cfgWord[`LCM_CFG_CASC_OR];
        packed_       = state.cfgWord[`LCM_CFG_PACKED];
        clockSel      = state.cfgWord[`LCM_CFG_CLK_SEL];
        presetMode    = state.cfgWord[`LCM_CFG_PRESET];
        chipResetUse  = state.cfgWord[`LCM_CFG_CHIP_RST];
        feedbackSel   = state.cfgWord[`LCM_CFG_FEEDBACK];
        presetLoadEmu = state.cfgWord[`LCM_CFG_PRE_LOAD];
    end

    // ----------------------------------------------------------------
    // input routing
    // ----------------------------------------------------------------
    logic feedback;
    logic feedbackOk;
    logic inA;
    logic inC;
    logic carryInUsed;

    // preset mode keeps the bit inverted, so the visible value is flipped
    assign feedback = state.stored ^ presetMode;

    // feedback on input a exists in the first cell and in every cell
    // except the second; elsewhere the selector is simply absent
    assign feedbackOk  = (CELL_POSITION == 0) || (CELL_POSITION != 1);
    assign inA         = (feedbackSel && feedbackOk) ? feedback : cellInputA;
    assign carryInUsed = (mode == LCM_MODE_NORMAL) && carryForC;
    assign inC         = carryInUsed ? carryIn : cellInputC;

    // ----------------------------------------------------------------
    // lookup tables
    // ----------------------------------------------------------------
    logic [3:0] lutIndex;
    logic [2:0] arithIndex;
    logic       lutOut;
    logic       sumOut;
    logic       arithCarry;

    assign lutIndex   = {cellInputD, inC, cellInputB, inA};
    assign arithIndex = {carryIn, cellInputB, inA};
    assign lutOut     = state.lutMask[lutIndex];
    // arithmetic splits the mask: low half result, high half carry
    assign sumOut     = state.lutMask[{1'b0, arithIndex}];
    assign arithCarry = state.lutMask[{1'b1, arithIndex}];

    // ----------------------------------------------------------------
    // counter tables
    // ----------------------------------------------------------------
    logic countEnable;
    logic countUp;
    logic countNext;
    logic countCarry;

    // the second cell cannot take enable or direction from its inputs
    assign countEnable = (CELL_POSITION == 1) ? 1'b1 : inA;
    assign countUp     = (CELL_POSITION == 1) ? 1'b1 : cellInputB;
    // a count wider than one cell chains carry out into the next carry in
    // carry-in means every lower bit is at its end value
    assign countNext   = feedback ^ (countEnable & carryIn);
    assign countCarry  = countEnable & carryIn & (countUp ? feedback : ~feedback);

    // ----------------------------------------------------------------
    // function result and cascade
    // ----------------------------------------------------------------
    logic funcOut;
    logic cascaded;

    always_comb
    begin
        case (mode)
            LCM_MODE_NORMAL:  funcOut = lutOut;
            LCM_MODE_ARITH:   funcOut = sumOut;
            LCM_MODE_COUNTER: funcOut = countNext;
            default:          funcOut = lutOut;
        endcase
    end

    // or form of the chain ORs cascade-in into the result, with nothing inverted
    always_comb
    begin
        if (!cascadeUse)
        begin
            cascaded = funcOut;
        end
        else if (cascadeOr)
        begin
            cascaded = funcOut | cascadeIn;
        end
        else
        begin
            cascaded = funcOut & cascadeIn;
        end
    end

    // ----------------------------------------------------------------
    // register data path
    // ----------------------------------------------------------------
    logic selectedEnable;
    logic regData;
    logic regNext;
    logic loaded;

    // the enable is tied to the clock the cell runs on
    assign selectedEnable = clockSel ? clusterClockEnableTwo : clusterClockEnableOne;

    // packing feeds input d straight to the register; carry-in use forbids it
    assign regData = (mode == LCM_MODE_NORMAL && packed_ && !carryInUsed) ?
                     cellInputD : cascaded;

    always_comb
    begin
        case (regType)
            LCM_REG_D:  regNext = regData;
            LCM_REG_T:  regNext = feedback ^ regData;
            LCM_REG_JK: regNext = (regData & ~feedback) | (~cellInputD & feedback);
            LCM_REG_SR: regNext = regData | (~cellInputD & feedback);
            default:    regNext = feedback;
        endcase
    end

    // load then clear after the chain: the clear AND sits last
    always_comb
    begin
        loaded = syncLoad ? cellInputC : regNext;
        if (syncClear)
        begin
            loaded = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    logic visibleReg;

    // with one clock a pulse that ends between edges moves only the output,
    // never the stored bit: hold async controls across an edge
    // async controls show at once, before the edge stores them
    always_comb
    begin
        if (asyncClear)
        begin
            visibleReg = presetMode;
        end
        else if (asyncLoad)
        begin
            visibleReg = cellInputC;
        end
        else
        begin
            visibleReg = feedback;
        end
    end

    assign combOut    = (mode == LCM_MODE_NORMAL || mode == LCM_MODE_ARITH) ?
                        cascaded : funcOut;
    assign regOut     = (regType == LCM_REG_BYPASS) ? cascaded : visibleReg;
    assign cascadeOut = cascaded;

    // normal mode has no carry chain of its own, so the link rests low
    always_comb
    begin
        case (mode)
            LCM_MODE_ARITH:   carryOut = arithCarry;
            LCM_MODE_COUNTER: carryOut = countCarry;
            default:          carryOut = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    logic setup;
    logic access;
    logic mapped;

    assign setup   = psel && !penable;
    assign access  = psel && penable;
    assign mapped  = (paddr == `LCM_OFS_CONFIG) || (paddr == `LCM_OFS_TABLE) ||
                     (paddr == `LCM_OFS_STATUS) || (paddr == `LCM_OFS_FORCE);
    // refusal is judged in setup; the address must hold through access
    assign pready  = access;
    assign prdata  = state.prdata;
    assign pslverr = access && state.pslverr;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    logic [31:0] readWord;
    logic [31:0] statusWord;

    always_comb
    begin
        statusWord                    = 32'h0000_0000;
        statusWord[`LCM_STS_REG]      = regOut;
        statusWord[`LCM_STS_COMB]     = combOut;
        statusWord[`LCM_STS_CARRY]    = carryOut;
        statusWord[`LCM_STS_CASC]     = cascadeOut;
        statusWord[`LCM_STS_UNDEF]    = state.undefinedFlag;
        statusWord[`LCM_STS_STORED]   = state.stored;
        case (paddr)
            `LCM_OFS_CONFIG: readWord = {18'h00000, state.cfgWord};
            `LCM_OFS_TABLE:  readWord = {16'h0000, state.lutMask};
            `LCM_OFS_STATUS: readWord = statusWord;
            default:         readWord = 32'h0000_0000;
        endcase
    end

    always_comb
    begin
        next_state = state;

        // answer data is latched in setup so the access phase needs no wait
        if (setup)
        begin
            next_state.prdata  = pwrite ? 32'h0000_0000 : readWord;
            next_state.pslverr = !mapped;
        end

        // a forced value loses to any enabled register update, async load, async clear or chip reset on the same edge
        if (access && pwrite)
        begin
            case (paddr)
                `LCM_OFS_CONFIG: next_state.cfgWord = pwdata[`LCM_CFG_WIDTH-1:0];
                `LCM_OFS_TABLE:  next_state.lutMask = pwdata[15:0];
                `LCM_OFS_FORCE:  next_state.stored  = pwdata[0] ^ presetMode;
                default:         next_state.lutMask = state.lutMask;
            endcase
        end

        // cell register, highest priority last
        if (selectedEnable)
        begin
            next_state.stored = loaded ^ presetMode;
            if (syncLoad || syncClear)
            begin
                next_state.undefinedFlag = 1'b0;
            end
        end
        if (asyncLoad)
        begin
            next_state.stored = cellInputC ^ presetMode;
        end
        if (asyncClear)
        begin
            next_state.stored = 1'b0;
        end
        if (chipResetUse && !chipResetN)
        begin
            // zero stored is the preset state when storage is inverted
            // an undefined value is only flagged; the bit itself still resets
            next_state.stored        = 1'b0;
            next_state.undefinedFlag = presetLoadEmu;
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            state.stored        <= 1'b0;
            state.undefinedFlag <= 1'b0;
            state.cfgWord       <= `LCM_RST_CONFIG;
            state.lutMask       <= `LCM_RST_TABLE;
            state.prdata        <= 32'h0000_0000;
            state.pslverr       <= 1'b0;
        end
        else
        begin
            state <= next_state;
        end
    end

endmodule

/* File: sim/lcm_cell_assertions.sv */
// Purpose: port checks of the logic cell
// Assumes: zero-wait APB slave; status word mirrors the cell outputs
// Notes:   sees only the ports of lcm_logic_cell
`timescale 1ns/10ps
module lcm_cell_checker
(
    input wire logic        clock,
    input wire logic        rstn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        regOut,
    input wire logic        combOut,
    input wire logic        carryOut,
    input wire logic        cascadeOut
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    wire logic acc = psel && penable;
    wire logic rdAcc = acc && !pwrite;

    a_ready_now: assert property (acc |-> pready)
        else $error("pready low in access phase");
    a_ready_idle: assert property (!acc |-> !pready)
        else $error("pready high outside access");
    a_err_access: assert property (pslverr |-> acc)
        else $error("pslverr outside access");
    // read data must not move under a master that samples late
    a_rdata_holds: assert property (acc |=> $stable(prdata))
        else $error("prdata moved after access");
    a_unmapped_err: assert property (acc && paddr > 8'h0C |->
        pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access not refused");
    a_mapped_ok: assert property (acc && paddr[7:3] == 5'h0 &&
        paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("mapped access refused");
    a_config_width: assert property (rdAcc && paddr == 8'h00 |-> prdata[31:14] == 18'h0)
        else $error("config read has stray bits");
    a_status_mirror: assert property (rdAcc && paddr == 8'h08 |->
        prdata[3:0] == $past({cascadeOut, carryOut, combOut, regOut}))
        else $error("status does not mirror outputs");

    c_refused: cover property (pslverr);
    c_status_read: cover property (rdAcc && paddr == 8'h08);
    c_reg_rise: cover property ($rose(regOut));
endmodule

bind lcm_logic_cell lcm_cell_checker lcm_cell_checker_i
(
    .clock(clock), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pready(pready), .prdata(prdata), .pslverr(pslverr), .regOut(regOut),
    .combOut(combOut), .carryOut(carryOut), .cascadeOut(cascadeOut)
);

/* File: sim/lcm_prev_cell.sv */
// Purpose: previous cell of the chain with its share of the cluster lines
// Assumes: counts up while chained and the shared enable is high
// Notes:   unchained, it hands on the values the bench asks for
`timescale 1ns/10ps
module lcm_prev_cell
(
    input  wire logic clock,
    input  wire logic rstn,
    input  wire logic chained,
    input  wire logic countEnable,
    input  wire logic syncClear,
    input  wire logic carryValue,
    input  wire logic cascadeValue,
    output logic      carryIn,
    output logic      cascadeIn
);
    logic lowBit;

    always_ff @(posedge clock)
    begin
        if (!rstn)
            lowBit <= 1'b0;
        else if (countEnable && syncClear)
            lowBit <= 1'b0;
        else if (countEnable && chained)
            lowBit <= ~lowBit;
    end
    // carry only on rollover, as a real lower bit of the counter would
    assign carryIn = chained ? (countEnable & lowBit) : carryValue;
    assign cascadeIn = cascadeValue;
endmodule

/* File: sim/lcm_logic_cell_tb.sv */
// Purpose: self-checking bench of the logic cell
// Assumes: zero-wait APB; the previous cell is lcm_prev_cell
// Notes:   first cell of the cluster, so count enable and direction are a and b
`timescale 1ns/10ps
module lcm_logic_cell_tb;
    import lcm_pkg::*;
    logic        clock, rstn, psel, penable, pwrite, pready, pslverr, e, held, ok, q;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, r;
    logic        inA, inB, inC, inD, casc, enOne, enTwo, aClr, aLoad, sClr, sLoad, chipRstN;
    logic        chained, carryVal, carryIn, cascadeIn, combOut, regOut, carryOut, cascadeOut;
    logic [15:0] tbl;
    logic [13:0] cfg;
    logic [19:0] row;
    logic [1:0]  cnt;
    int          failures = 0;
    int          num_checks = 0;
    // row: config, enable, sync clear, sync load, c, async clear, chip reset n, cascade,
    // expected register; never more than six shared lines at once
    logic [19:0] rows [10] = '{20'h003B5, 20'h003F4, 20'h00BB5, 20'h00345, 20'h0030C,
                               20'h000B5, 20'h800B0, 20'hC0001, 20'h000B5, 20'h00001};

    lcm_logic_cell lcm_logic_cell_i
    (
        .clock(clock), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .cellInputA(inA), .cellInputB(inB), .cellInputC(inC), .cellInputD(inD),
        .carryIn(carryIn), .cascadeIn(cascadeIn), .clusterClockEnableOne(enOne),
        .clusterClockEnableTwo(enTwo), .asyncClear(aClr), .asyncLoad(aLoad),
        .syncClear(sClr), .syncLoad(sLoad), .chipResetN(chipRstN), .combOut(combOut),
        .regOut(regOut), .carryOut(carryOut), .cascadeOut(cascadeOut)
    );
    lcm_prev_cell lcm_prev_cell_i
    (
        .clock(clock), .rstn(rstn), .chained(chained), .countEnable(enOne),
        .syncClear(sClr), .carryValue(carryVal), .cascadeValue(casc),
        .carryIn(carryIn), .cascadeIn(cascadeIn)
    );

    function automatic logic lut(logic [15:0] t, logic i3, logic i2, logic i1, logic i0);
        return t[{i3, i2, i1, i0}];
    endfunction

    task automatic chkBit(input string what, input logic exp, input logic got);
        num_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic chkWord(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic conclude;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        if (n >= 16)
        begin
            failures++;
            conclude();
        end
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
        @(posedge clock);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0);
        chkWord(what, exp, r);
    endtask

    task automatic settle;
        @(posedge clock);
        @(negedge clock);
    endtask

    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    initial
    begin
        void'($urandom(32'h302F82F0));
        {rstn, psel, penable, pwrite, paddr, pwdata} = '0;
        {inA, inB, inC, inD, casc, enOne, enTwo, aClr, aLoad, sClr, sLoad} = '0;
        {chipRstN, chained, carryVal} = 3'b100;
        repeat (12) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        rd(8'h00, 32'h0, "config reset");
        rd(8'h04, 32'h0, "table reset");
        tbl = 16'($urandom);
        apb(1'b1, 8'h04, {16'h0, tbl});
        rd(8'h04, {16'h0, tbl}, "table");
        apb(1'b0, 8'h10, 32'h0);
        chkBit("unmapped error", 1'b1, e);
        for (int k = 0; k < 8; k++)
        begin
            cfg = 14'(k << 2);
            apb(1'b1, 8'h00, {18'h0, cfg});
            rd(8'h00, {18'h0, cfg}, "config");
            repeat (6)
            begin
                {inA, inB, inC, inD, carryVal, casc} <= 6'($urandom);
                @(negedge clock);
                q = lut(tbl, inD, cfg[2] ? carryVal : inC, inB, inA);
                if (cfg[3])
                    chkBit("cascade", cfg[4] ? (q | casc) : (q & casc), cascadeOut);
                else
                    chkBit("lut", q, combOut);
                @(posedge clock);
            end
        end
        for (int p = 0; p < 2; p++)
        begin
            apb(1'b1, 8'h00, p ? 32'h49 : 32'h1);
            ok = 1'b0;
            repeat (10)
            begin
                {inA, inB, carryVal, enOne, enTwo, casc} <= 6'($urandom);
                @(negedge clock);
                q = lut(tbl, 1'b0, carryVal, inB, inA) & (casc | !p);
                chkBit("sum", q, combOut);
                chkBit("carry out", lut(tbl, 1'b1, carryVal, inB, inA), carryOut);
                if (ok)
                    chkBit("registered sum", held, regOut);
                if (p ? enTwo : enOne)
                begin
                    held = q;
                    ok = 1'b1;
                end
                @(posedge clock);
            end
        end
        apb(1'b1, 8'h00, 32'h3);
        {chained, inA, inB, enOne, enTwo, sClr} <= 6'b111101;
        @(posedge clock);
        sClr <= 1'b0;
        cnt = 2'h0;
        repeat (9)
        begin
            @(negedge clock);
            chkBit("count", cnt[1], regOut);
            chkBit("count carry", &cnt, carryOut);
            @(posedge clock);
            cnt = cnt + 2'h1;
        end
        {chained, carryVal, inB} <= 3'b010;
        q = cnt[1];
        repeat (4)
        begin
            @(negedge clock);
            chkBit("down count", q, regOut);
            chkBit("down carry", ~q, carryOut);
            @(posedge clock);
            q = ~q;
        end
        {carryVal, inB, enOne} <= 3'b010;
        for (int i = 0; i < 10; i++)
        begin
            row = rows[i];
            apb(1'b1, 8'h00, {20'h0, row[19:8]});
            {enOne, sClr, sLoad, inC, aClr, chipRstN, casc} <= row[7:1];
            settle();
            chkBit("control", row[0], regOut);
            @(posedge clock);
            {enOne, sClr, sLoad, aClr, chipRstN} <= 5'b00001;
        end
        {aLoad, inC} <= 2'b10;
        @(negedge clock);
        chkBit("async load", 1'b0, regOut);
        @(posedge clock);
        aLoad <= 1'b0;
        settle();
        chkBit("async load kept", 1'b0, regOut);
        @(posedge clock);
        apb(1'b1, 8'h00, 32'h20);
        q = 1'($urandom);
        {enOne, inD} <= {1'b1, q};
        settle();
        chkBit("packed", q, regOut);
        @(posedge clock);
        apb(1'b1, 8'h00, 32'h24);
        settle();
        q = lut(tbl, q, carryVal, inB, inA);
        chkBit("packed off", q, regOut);
        @(posedge clock);
        {enOne, inA} <= {1'b0, ~q};
        apb(1'b1, 8'h00, 32'h1000);
        @(negedge clock);
        chkBit("feedback", lut(tbl, inD, inC, inB, q), combOut);
        @(posedge clock);
        apb(1'b1, 8'h00, 32'h200);
        @(negedge clock);
        chkBit("bypass", lut(tbl, inD, inC, inB, inA), regOut);
        @(posedge clock);
        apb(1'b1, 8'h00, 32'h2800);
        chipRstN <= 1'b0;
        settle();
        @(posedge clock);
        chipRstN <= 1'b1;
        apb(1'b0, 8'h08, 32'h0);
        chkBit("undefined flag", 1'b1, r[4]);
        conclude();
    end
endmodule
